// file: hw/adc_averager.sv
// Accumulator that averages a power-of-two number of samples
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_averager (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Sample stream
   input wire logic clear,
   input wire logic add,
   input wire logic [`CODE_W-1:0] sample,
   // Result
   input wire logic [`SHIFT_W-1:0] shift,
   output logic [`CODE_W-1:0] mean
);
   import adc_ctrl_pkg::*;

   avg_state_type st_r;
   avg_state_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt.sum = '0;
      end else if (add) begin
         st_nxt.sum = st_r.sum + `ACC_W'(sample);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Truncating divide by the point count
   assign mean = `CODE_W'(st_r.sum >> shift);

endmodule

// file: hw/adc_measure_control_readback.sv
// Measurement sequencer and register file for the monitoring converter
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_measure_control_readback #(
   parameter adc_ctrl_pkg::ticks_type TICKS_R0 =
      adc_ctrl_pkg::ticks_type'(`CLK_HZ / `RATE0_HZ),
   parameter adc_ctrl_pkg::ticks_type TICKS_R1 =
      adc_ctrl_pkg::ticks_type'(`CLK_HZ / `RATE1_HZ),
   parameter adc_ctrl_pkg::ticks_type TICKS_R2 =
      adc_ctrl_pkg::ticks_type'(`CLK_HZ / `RATE2_HZ),
   parameter adc_ctrl_pkg::ticks_type TICKS_R3 =
      adc_ctrl_pkg::ticks_type'(`CLK_HZ / `RATE3_HZ)
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port from the serial engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`BYTE_W-1:0] reg_addr,
   input wire logic [`BYTE_W-1:0] reg_wdata,
   output logic [`BYTE_W-1:0] reg_rdata,
   output logic reg_rdata_valid,
   // Converter core
   output logic conv_start,
   output logic [`CH_W-1:0] conv_channel,
   input wire logic conv_done,
   input wire logic [`CODE_W-1:0] conv_code,
   // Finished channel results
   output logic result_valid,
   output logic [`CH_W-1:0] result_channel,
   output logic [`CODE_W-1:0] result_code,
   // Sequencer status
   output logic busy
);
   import adc_ctrl_pkg::*;

   ctrl_state_type st_r;
   ctrl_state_type st_nxt;

   logic tick;
   logic timer_restart;
   logic avg_clear;
   logic avg_add;
   logic [`CODE_W-1:0] avg_mean;

   // Rate tick, restarted at each sweep
   adc_rate_timer #(
      .TICKS_R0(TICKS_R0),
      .TICKS_R1(TICKS_R1),
      .TICKS_R2(TICKS_R2),
      .TICKS_R3(TICKS_R3)
   ) u_timer (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .rate_sel(st_r.rate),
      .restart(timer_restart),
      .tick(tick)
   );

   // Point accumulator for one channel
   adc_averager u_avg (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clear(avg_clear),
      .add(avg_add),
      .sample(conv_code),
      .shift(st_r.shift),
      .mean(avg_mean)
   );

   // Index of the last sample for a given point count
   function automatic logic [`SAMPLE_CNT_W-1:0] last_sample(
      input logic [`SHIFT_W-1:0] shift
   );
      logic [`SAMPLE_CNT_W:0] cnt;
      cnt = (`SAMPLE_CNT_W+1)'(1) << shift;
      last_sample = `SAMPLE_CNT_W'(cnt - (`SAMPLE_CNT_W+1)'(1));
   endfunction

   // Fresh sweep from the first channel
   function automatic ctrl_state_type begin_sweep(
      input ctrl_state_type s
   );
      ctrl_state_type r;
      r = s;
      r.sweep_single = s.single;
      r.rearm = 1'b0;
      r.tick_seen = 1'b0;
      r.ch_idx = '0;
      r.state = S_PICK;
      begin_sweep = r;
   endfunction

   // Step past the current channel, ending after the last
   function automatic ctrl_state_type advance(
      input ctrl_state_type s
   );
      ctrl_state_type r;
      r = s;
      if (s.ch_idx == `LAST_CH_IDX) begin
         r.state = S_END;
      end else begin
         r.ch_idx = s.ch_idx + `CH_W'(1);
         r.state = S_PICK;
      end
      advance = r;
   endfunction

   // Upper result nibble, reserved bits at zero
   function automatic logic [`BYTE_W-1:0] high_byte(input code_type c);
      high_byte = `BYTE_W'(c[`CODE_W-1:`BYTE_W]);
   endfunction

   // Lower result byte
   function automatic logic [`BYTE_W-1:0] low_byte(input code_type c);
      low_byte = c[`BYTE_W-1:0];
   endfunction

   // Control fields come out of reset from this byte
   localparam logic [`BYTE_W-1:0] CTRL_RST = `RST_CONV_CTRL;

   // Register read mux
   function automatic logic [`BYTE_W-1:0] read_byte(
      input ctrl_state_type s,
      input logic [`BYTE_W-1:0] addr
   );
      logic [`BYTE_W-1:0] d;
      d = `UNMAPPED_READ;
      unique case (addr)
         `ADDR_CH_ENABLES: begin
            d = s.ch_en;
         end
         `ADDR_CONV_CTRL: begin
            d = {s.rate, s.avg_pts, s.spare, s.avg_on, s.cont, s.single};
         end
         `ADDR_VIN_HIGH: begin
            d = high_byte(s.vin_code);
         end
         `ADDR_VIN_LOW: begin
            d = low_byte(s.vin_code);
         end
         `ADDR_AUX_HIGH: begin
            d = high_byte(s.aux_code);
         end
         `ADDR_AUX_LOW: begin
            d = low_byte(s.aux_code);
         end
         default: begin
            d = `UNMAPPED_READ;
         end
      endcase
      read_byte = d;
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.conv_start = 1'b0;
      st_nxt.res_valid = 1'b0;
      st_nxt.rd_valid = 1'b0;
      timer_restart = 1'b0;
      avg_clear = 1'b0;
      avg_add = 1'b0;
      if (tick) begin
         st_nxt.tick_seen = 1'b1;
      end

      unique case (st_r.state)
         S_IDLE: begin
            if (st_r.single || st_r.cont) begin
               st_nxt = begin_sweep(st_nxt);
               timer_restart = 1'b1;
            end
         end
         S_PICK: begin
            if (st_r.ch_en[st_r.ch_idx]) begin
               st_nxt.shift = avg_shift(st_r.avg_on, st_r.avg_pts);
               st_nxt.n = '0;
               avg_clear = 1'b1;
               st_nxt.state = S_START;
            end else begin
               st_nxt = advance(st_nxt);
            end
         end
         S_START: begin
            st_nxt.conv_start = 1'b1;
            st_nxt.conv_ch = st_r.ch_idx;
            st_nxt.state = S_WAIT;
         end
         S_WAIT: begin
            if (conv_done) begin
               avg_add = 1'b1;
               st_nxt.n = st_r.n + `SAMPLE_CNT_W'(1);
               if (st_r.n == last_sample(st_r.shift)) begin
                  st_nxt.state = S_STORE;
               end else begin
                  st_nxt.state = S_START;
               end
            end
         end
         S_STORE: begin
            if (st_r.ch_idx == `VIN_CH_IDX) begin
               st_nxt.vin_code = avg_mean;
            end
            if (st_r.ch_idx == `AUX_CH_IDX) begin
               st_nxt.aux_code = avg_mean;
            end
            st_nxt.res_valid = 1'b1;
            st_nxt.res_ch = st_r.ch_idx;
            st_nxt.res_code = avg_mean;
            st_nxt = advance(st_nxt);
         end
         S_END: begin
            if (st_r.sweep_single) begin
               st_nxt.single = st_r.rearm;
            end
            st_nxt.state = S_REST;
         end
         S_REST: begin
            if (st_r.single) begin
               st_nxt = begin_sweep(st_nxt);
               timer_restart = 1'b1;
            end else if (!st_r.cont) begin
               st_nxt.state = S_IDLE;
            end else if (st_r.tick_seen || tick) begin
               st_nxt = begin_sweep(st_nxt);
               timer_restart = 1'b1;
            end
         end
         default: begin
            st_nxt.state = S_IDLE;
         end
      endcase

      // Host writes; result registers ignore them
      if (reg_wr) begin
         if (reg_addr == `ADDR_CH_ENABLES) begin
            st_nxt.ch_en = reg_wdata;
         end
         if (reg_addr == `ADDR_CONV_CTRL) begin
            st_nxt.rate = reg_wdata[`CTRL_RATE_HI:`CTRL_RATE_LO];
            st_nxt.avg_pts = reg_wdata[`CTRL_PTS_HI:`CTRL_PTS_LO];
            st_nxt.avg_on = reg_wdata[`CTRL_AVG_ON_BIT];
            st_nxt.spare = reg_wdata[`CTRL_SPARE_BIT];
            st_nxt.cont = reg_wdata[`CTRL_CONT_BIT];
            if (reg_wdata[`CTRL_ONESHOT_BIT]) begin
               st_nxt.single = 1'b1;
               st_nxt.rearm = 1'b1;
            end
         end
      end

      if (reg_rd) begin
         st_nxt.rd_data = read_byte(st_r, reg_addr);
         st_nxt.rd_valid = 1'b1;
      end

      st_nxt.busy = (st_nxt.state != S_IDLE) && (st_nxt.state != S_REST);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.state <= S_IDLE;
         st_r.ch_en <= `RST_CH_ENABLES;
         st_r.rate <= CTRL_RST[`CTRL_RATE_HI:`CTRL_RATE_LO];
         st_r.avg_pts <= CTRL_RST[`CTRL_PTS_HI:`CTRL_PTS_LO];
         st_r.spare <= CTRL_RST[`CTRL_SPARE_BIT];
         st_r.avg_on <= CTRL_RST[`CTRL_AVG_ON_BIT];
         st_r.cont <= CTRL_RST[`CTRL_CONT_BIT];
         st_r.single <= CTRL_RST[`CTRL_ONESHOT_BIT];
         st_r.vin_code <= `RST_RESULT;
         st_r.aux_code <= `RST_RESULT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata = st_r.rd_data;
   assign reg_rdata_valid = st_r.rd_valid;
   assign conv_start = st_r.conv_start;
   assign conv_channel = st_r.conv_ch;
   assign result_valid = st_r.res_valid;
   assign result_channel = st_r.res_ch;
   assign result_code = st_r.res_code;
   assign busy = st_r.busy;

endmodule

// file: hw/adc_rate_timer.sv
// Sample-rate tick generator for the conversion sequencer
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_rate_timer #(
   parameter adc_ctrl_pkg::ticks_type TICKS_R0 = 1,
   parameter adc_ctrl_pkg::ticks_type TICKS_R1 = 1,
   parameter adc_ctrl_pkg::ticks_type TICKS_R2 = 1,
   parameter adc_ctrl_pkg::ticks_type TICKS_R3 = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Control
   input wire logic [1:0] rate_sel,
   input wire logic restart,
   // Period elapsed
   output logic tick
);
   import adc_ctrl_pkg::*;

   timer_state_type st_r;
   timer_state_type st_nxt;

   function automatic ticks_type period_of(input logic [1:0] sel);
      ticks_type p;
      p = TICKS_R0;
      unique case (sel)
         2'h0: p = TICKS_R0;
         2'h1: p = TICKS_R1;
         2'h2: p = TICKS_R2;
         2'h3: p = TICKS_R3;
      endcase
      period_of = p - ticks_type'(1);
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (restart) begin
         // Tick is acted on an edge later, so reload one short
         st_nxt.count = period_of(rate_sel);
         if (st_nxt.count != '0) begin
            st_nxt.count = st_nxt.count - ticks_type'(1);
         end
      end else if (st_r.count == '0) begin
         st_nxt.count = period_of(rate_sel);
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.count = st_r.count - ticks_type'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule

// file: inc/adc_ctrl_consts.svh
// Register map, field positions, reset values and timing for the ADC block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

`define BYTE_W 8
`define CODE_W 12
`define NIBBLE_W 4
`define NUM_CH 8
`define CH_W 3
`define SHIFT_W 3
`define SAMPLE_CNT_W 4
`define ACC_W 16
`define TIMER_W 25

`define ADDR_CH_ENABLES 8'h30
`define ADDR_CONV_CTRL 8'h31
`define ADDR_VIN_HIGH 8'h32
`define ADDR_VIN_LOW 8'h33
`define ADDR_AUX_HIGH 8'h34
`define ADDR_AUX_LOW 8'h35

`define RST_CH_ENABLES 8'h00
`define RST_CONV_CTRL 8'h00
`define RST_RESULT 12'h000
`define UNMAPPED_READ 8'h00

`define CTRL_RATE_HI 7
`define CTRL_RATE_LO 6
`define CTRL_PTS_HI 5
`define CTRL_PTS_LO 4
`define CTRL_SPARE_BIT 3
`define CTRL_AVG_ON_BIT 2
`define CTRL_CONT_BIT 1
`define CTRL_ONESHOT_BIT 0

`define VIN_CH_IDX 3'h0
`define AUX_CH_IDX 3'h1
`define LAST_CH_IDX 3'h7

`define VIN_FULL_SCALE_MV 25000
`define AUX_FULL_SCALE_MV 1250

`define CLK_HZ 20000000
`define RATE0_HZ 1000
`define RATE1_HZ 100
`define RATE2_HZ 10
`define RATE3_HZ 1

`endif

// file: inc/adc_ctrl_pkg.sv
// Types shared by the ADC control block and its helpers
`include "adc_ctrl_consts.svh"

package adc_ctrl_pkg;

   typedef logic [`TIMER_W-1:0] ticks_type;
   typedef logic [`CODE_W-1:0] code_type;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_PICK = 7'h02,
      S_START = 7'h04,
      S_WAIT = 7'h08,
      S_STORE = 7'h10,
      S_END = 7'h20,
      S_REST = 7'h40
   } seq_state_type;

   typedef struct packed {
      ticks_type count;
      logic tick;
   } timer_state_type;

   typedef struct packed {
      logic [`ACC_W-1:0] sum;
   } avg_state_type;

   typedef struct packed {
      seq_state_type state;
      logic [`NUM_CH-1:0] ch_en;
      logic [1:0] rate;
      logic [1:0] avg_pts;
      logic spare;
      logic avg_on;
      logic cont;
      logic single;
      logic rearm;
      logic sweep_single;
      logic tick_seen;
      logic [`CH_W-1:0] ch_idx;
      logic [`SAMPLE_CNT_W-1:0] n;
      logic [`SHIFT_W-1:0] shift;
      code_type vin_code;
      code_type aux_code;
      logic [`BYTE_W-1:0] rd_data;
      logic rd_valid;
      logic conv_start;
      logic [`CH_W-1:0] conv_ch;
      logic res_valid;
      logic [`CH_W-1:0] res_ch;
      code_type res_code;
      logic busy;
   } ctrl_state_type;

   // Averaging off means one sample, otherwise 2 to the (code+1)
   function automatic logic [`SHIFT_W-1:0] avg_shift(
      input logic on,
      input logic [1:0] pts
   );
      avg_shift = on ? (`SHIFT_W'(pts) + `SHIFT_W'(1)) : '0;
   endfunction

endpackage

// file: verif/adc_conv_model.sv
// Converter core model answering each start after a set delay
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_conv_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Test settings
   input wire logic [3:0] delay,
   input wire logic wobble,
   input wire logic [`CODE_W-1:0] code0,
   input wire logic [`CODE_W-1:0] code1,
   // Converter link
   input wire logic conv_start,
   input wire logic [`CH_W-1:0] conv_channel,
   output logic conv_done,
   output logic [`CODE_W-1:0] conv_code
);
   logic pend_r;
   logic flip_r;
   logic [3:0] cnt_r;
   logic [`CH_W-1:0] ch_r;
   logic [`CODE_W-1:0] base;

   always_comb begin
      case (ch_r)
         `VIN_CH_IDX: base = code0;
         `AUX_CH_IDX: base = code1;
         default: base = {1'b0, ch_r, 8'h5A};
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pend_r <= 1'b0;
         flip_r <= 1'b0;
         cnt_r <= 4'h0;
         ch_r <= '0;
         conv_done <= 1'b0;
         conv_code <= '0;
      end else begin
         conv_done <= 1'b0;
         // Code is meaningless outside the done cycle
         conv_code <= ~conv_code;
         if (pend_r && cnt_r == 4'h0) begin
            pend_r <= 1'b0;
            conv_done <= 1'b1;
            conv_code <= base + ((wobble && flip_r) ? 12'h002 : 12'h000);
            flip_r <= ~flip_r;
         end else if (pend_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
         if (conv_start) begin
            pend_r <= 1'b1;
            cnt_r <= delay;
            ch_r <= conv_channel;
         end
      end
   end
endmodule

// file: verif/adc_ctrl_properties.sv
// Port assertions for the ADC control and readback block
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_ctrl_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`BYTE_W-1:0] reg_addr,
   input wire logic [`BYTE_W-1:0] reg_wdata,
   input wire logic [`BYTE_W-1:0] reg_rdata,
   input wire logic reg_rdata_valid,
   // Converter and results
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic result_valid,
   input wire logic [`CH_W-1:0] result_channel,
   input wire logic [`CODE_W-1:0] result_code,
   input wire logic busy
);
   logic [`CODE_W-1:0] vin_r;
   logic [`CODE_W-1:0] aux_r;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // Last reported code of each channel with registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vin_r <= '0;
         aux_r <= '0;
      end else if (result_valid && result_channel == `VIN_CH_IDX) begin
         vin_r <= result_code;
      end else if (result_valid && result_channel == `AUX_CH_IDX) begin
         aux_r <= result_code;
      end
   end

   AST_READ_ANSWERED: assert property (reg_rd |=> reg_rdata_valid)
      else $error("read strobe not answered");
   AST_VALID_ONLY_READ: assert property (
      reg_rdata_valid |-> $past(reg_rd)) else $error("spurious read valid");
   AST_ENABLE_READBACK: assert property (
      (reg_wr && reg_addr == `ADDR_CH_ENABLES) ##1 !reg_wr ##1
      (reg_rd && reg_addr == `ADDR_CH_ENABLES) |=>
      reg_rdata == $past(reg_wdata, 3)) else $error("enable readback wrong");
   AST_VIN_HIGH: assert property (
      reg_rd && reg_addr == `ADDR_VIN_HIGH |=> reg_rdata == {4'h0, vin_r[11:8]})
      else $error("input voltage high byte wrong");
   AST_VIN_LOW: assert property (
      reg_rd && reg_addr == `ADDR_VIN_LOW |=> reg_rdata == vin_r[7:0])
      else $error("input voltage low byte wrong");
   AST_AUX_HIGH: assert property (
      reg_rd && reg_addr == `ADDR_AUX_HIGH |=> reg_rdata == {4'h0, aux_r[11:8]})
      else $error("aux high byte wrong");
   AST_AUX_LOW: assert property (
      reg_rd && reg_addr == `ADDR_AUX_LOW |=> reg_rdata == aux_r[7:0])
      else $error("aux low byte wrong");
   AST_RESULT_AFTER_DONE: assert property (
      result_valid |-> $past(conv_done, 2)) else $error("result without done");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("start held longer than one cycle");
   AST_BUSY_WITH_START: assert property (conv_start |-> busy)
      else $error("start while not busy");

   COV_VIN: cover property (result_valid && result_channel == `VIN_CH_IDX);
   COV_AUX: cover property (result_valid && result_channel == `AUX_CH_IDX);
   COV_BACK_TO_BACK: cover property (conv_done ##1 conv_start);
endmodule

bind adc_measure_control_readback adc_ctrl_properties chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rdata_valid(reg_rdata_valid), .conv_start(conv_start),
   .conv_done(conv_done), .result_valid(result_valid),
   .result_channel(result_channel), .result_code(result_code), .busy(busy));

// file: verif/tb_top.sv
// Self-checking bench for the ADC control and readback block
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module tb_top;
   import adc_ctrl_pkg::*;
   localparam int TK [4] = '{20, 40, 60, 80};
   localparam logic [7:0] OS_EN [3] = '{8'h03, 8'h03, 8'h02};
   localparam logic [11:0] OS_C0 [3] = '{12'hABC, 12'hFFF, 12'h123};
   localparam logic [11:0] OS_C1 [3] = '{12'h5F3, 12'h000, 12'h456};
   localparam logic [3:0] OS_D [3] = '{4'h0, 4'h7, 4'h3};
   logic clk_sys, arst_n, reg_wr, reg_rd, reg_rdata_valid, busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic conv_start, conv_done, result_valid, wobble;
   logic [2:0] conv_channel, result_channel;
   logic [11:0] conv_code, result_code, code0, code1, ev, ea;
   logic [3:0] delay;
   int mismatches, tests_run, i, n;

   adc_measure_control_readback #(.TICKS_R0(ticks_type'(20)),
      .TICKS_R1(ticks_type'(40)), .TICKS_R2(ticks_type'(60)),
      .TICKS_R3(ticks_type'(80))) dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rdata_valid(reg_rdata_valid), .conv_start(conv_start),
      .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_code(conv_code), .result_valid(result_valid),
      .result_channel(result_channel), .result_code(result_code),
      .busy(busy));
   adc_conv_model conv (.clk_sys(clk_sys), .arst_n(arst_n), .delay(delay),
      .wobble(wobble), .code0(code0), .code1(code1),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_code(conv_code));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [15:0] seen, e);
      tests_run++;
      if (seen !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, e, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, e);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      chk("read valid", {15'h0, reg_rdata_valid}, 16'h1);
      chk($sformatf("reg %h", a), {8'h0, reg_rdata}, {8'h0, e});
      @(posedge clk_sys);
      #1;
   endtask

   task automatic next_start(input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk_sys);
         #1;
         c++;
      end while (conv_start !== 1'b1 && c < lim);
   endtask

   // Counts starts until the sweep is over
   task automatic sweep(output int c);
      c = 0;
      for (int k = 0; k < 3000; k++) begin
         @(posedge clk_sys);
         #1;
         if (conv_start === 1'b1) c++;
         if (k > 3 && busy === 1'b0) break;
      end
      chk("sweep end", {15'h0, busy}, 16'h0);
   endtask

   task automatic results;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #(30000 * 50);
      mismatches++;
      results();
   end

   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, wobble} = '0;
      {code0, code1, delay, ev, ea} = '0;
      arst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      for (i = 8'h2F; i <= 8'h36; i++) rd(8'(i), 8'h00);
      wr(8'h30, 8'hA5);
      rd(8'h30, 8'hA5);
      wr(8'h31, 8'hF8);
      rd(8'h31, 8'hF8);
      for (i = 8'h32; i <= 8'h35; i++) begin
         wr(8'(i), 8'hFF);
         rd(8'(i), 8'h00);
      end
      for (i = 0; i < 3; i++) begin
         code0 = OS_C0[i];
         code1 = OS_C1[i];
         delay = OS_D[i];
         wr(8'h30, OS_EN[i]);
         wr(8'h31, 8'h01);
         sweep(n);
         chk("starts", 16'(n), 16'(OS_EN[i][0]) + 16'(OS_EN[i][1]));
         rd(8'h31, 8'h00);
         if (OS_EN[i][0]) ev = OS_C0[i];
         if (OS_EN[i][1]) ea = OS_C1[i];
         rd(8'h32, {4'h0, ev[11:8]});
         rd(8'h33, ev[7:0]);
         rd(8'h34, {4'h0, ea[11:8]});
         rd(8'h35, ea[7:0]);
      end
      code0 = 12'h700;
      code1 = 12'h0FE;
      wobble = 1'b1;
      delay = 4'h1;
      wr(8'h30, 8'h03);
      for (i = 0; i < 4; i++) begin
         wr(8'h31, 8'h05 | 8'(i << 4));
         sweep(n);
         chk("averaged starts", 16'(n), 16'(4 << i));
         rd(8'h33, 8'h01);
         rd(8'h35, 8'hFF);
      end
      wr(8'h31, 8'h31);
      sweep(n);
      chk("unaveraged starts", 16'(n), 16'h2);
      wobble = 1'b0;
      wr(8'h30, 8'h01);
      for (i = 0; i < 4; i++) begin
         wr(8'h31, 8'(i << 6) | 8'h02);
         next_start(1000, n);
         next_start(1000, n);
         chk("sweep period", 16'(n), 16'(TK[i]));
         wr(8'h31, 8'h00);
         sweep(n);
      end
      next_start(300, n);
      chk("stopped", 16'(n), 16'd300);
      results();
   end
endmodule
